// ### logic/otpsf_map.svh
// Offsets, field positions, reset values and timing counts of the special-function control bank.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef OTPSF_MAP_SVH
`define OTPSF_MAP_SVH

// Register offsets
`define OTPSF_ADDR_PROG_LOCK 8'h15
`define OTPSF_ADDR_SPECIAL_ONE 8'h16
`define OTPSF_ADDR_SPECIAL_TWO 8'h17
`define OTPSF_ADDR_LOCKOUT 8'h18

// fuse_program_lock fields
`define OTPSF_PL_LOCK_BIT 3

// special_control_one fields
`define OTPSF_S1_SENSE_BIT 0
`define OTPSF_S1_BLOW_BIT 1
`define OTPSF_S1_SHUTDOWN_BIT 2
`define OTPSF_S1_OVR_BIT 3

// special_control_two fields
`define OTPSF_S2_PDOWN_BIT 0

// special_feature_lockout fields
`define OTPSF_LK_OVR_BIT 0
`define OTPSF_LK_OTP_BIT 1
`define OTPSF_LK_PDOWN_BIT 3
`define OTPSF_LK_SHUTDOWN_BIT 4
`define OTPSF_LK_MASK 8'h1b

// Reset values
`define OTPSF_SPECIAL_ONE_RESET 8'h00
`define OTPSF_SPECIAL_TWO_RESET 8'h00
`define OTPSF_LOCKOUT_RESET 8'h00

// Timing
`define OTPSF_CLK_PERIOD_NS 5
`define OTPSF_FUSE_BLOW_NS 1000
`define OTPSF_FUSE_BLOW_CYCLES (`OTPSF_FUSE_BLOW_NS / `OTPSF_CLK_PERIOD_NS)

`endif

// ### logic/otpsf_pkg.sv
// Types shared by the special-function control bank and its fuse sequencer.
// Assumes otpsf_map.svh supplies all numeric constants.
package otpsf_pkg;

    typedef enum logic [1:0]
    {
        OTPSF_SEQ_IDLE = 2'b00,
        OTPSF_SEQ_BLOW = 2'b01,
        OTPSF_SEQ_DONE = 2'b10
    } otpsf_seq_state_t;

    typedef struct packed
    {
        otpsf_seq_state_t state;
        logic [15:0] count;
        logic blow;
        logic busy;
    } otpsf_seq_t;

    typedef struct packed
    {
        logic sense_low;
        logic blow_en;
        logic sw_shutdown;
        logic override;
        logic sw_pdown;
        logic [7:0] lockout;
        logic burn_start;
        logic [7:0] rdata;
        logic rd_hit;
        logic shutdown_out_n;
        logic power_down;
        logic override_active;
        logic fuse_blow_enable;
        logic reg_override_allow;
        logic otp_allow;
    } otpsf_ctrl_t;

endpackage

// ### logic/otpsf_fuse_if.sv
// Carrier between the control bank and the fuse blow sequencer.
// Both ends share the control bank's clock.
interface otpsf_fuse_if;
    logic start;
    logic busy;
    logic blow;

    modport ctrl
    (
        output start,
        input busy,
        input blow
    );

    modport seq
    (
        input start,
        output busy,
        output blow
    );
endinterface

// ### logic/otpsf_fuse_seq.sv
// Fuse blow sequencer: one start request gives one blow pulse of fixed length.
// Assumes start is a one-cycle pulse from the control bank, honoured only while idle.
`include "otpsf_map.svh"

module otpsf_fuse_seq
#(
    parameter int unsigned BLOW_CYCLES = `OTPSF_FUSE_BLOW_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control side
    otpsf_fuse_if.seq fuse
);

    localparam logic [15:0] BLOW_LAST = 16'(BLOW_CYCLES - 1);

    otpsf_pkg::otpsf_seq_t st;
    otpsf_pkg::otpsf_seq_t next_st;

    always_comb
    begin
        next_st = st;
        case (st.state)
            otpsf_pkg::OTPSF_SEQ_IDLE:
            begin
                if (fuse.start)
                begin
                    next_st.state = otpsf_pkg::OTPSF_SEQ_BLOW;
                    next_st.count = 16'h0000;
                    next_st.blow = 1'b1;
                end
            end
            otpsf_pkg::OTPSF_SEQ_BLOW:
            begin
                if (st.count == BLOW_LAST)
                begin
                    next_st.state = otpsf_pkg::OTPSF_SEQ_DONE;
                    next_st.blow = 1'b0;
                end
                else
                begin
                    next_st.count = st.count + 16'h0001;
                end
            end
            otpsf_pkg::OTPSF_SEQ_DONE:
            begin
                // One settle cycle so the fuse sense sees a finished blow
                next_st.state = otpsf_pkg::OTPSF_SEQ_IDLE;
            end
            default:
            begin
                next_st.state = otpsf_pkg::OTPSF_SEQ_IDLE;
                next_st.blow = 1'b0;
            end
        endcase
        // Busy is registered so the bank's output comes straight from a flop
        next_st.busy = (next_st.state != otpsf_pkg::OTPSF_SEQ_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st.state <= otpsf_pkg::OTPSF_SEQ_IDLE;
            st.count <= 16'h0000;
            st.blow <= 1'b0;
            st.busy <= 1'b0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign fuse.blow = st.blow;
    assign fuse.busy = st.busy;

endmodule // otpsf_fuse_seq

// ### logic/otpsf_ctrl.sv
// Special-function control bank: fuse program lock, special controls one and two, feature lockout.
// Assumes the serial core presents byte accesses on wr_en/rd_en with addr and wdata, one cycle each,
// and that the fuse array reports the burned program lock as a level synchronous to clk.
//
// What this block does
// - A burned program lock inhibits every further fuse programming, as do lockout bit 1 and a clear special control one bit 1.
// - The program lock acts only once burned into the fuse store, never from a volatile bit.
// - Special control one bit 0 selects the fuse readback sense current, 0 for 5 uA and 1 for 0.55 uA.
// - Special control one bit 1 must be one for any fuse to be blown.
// - Special control one bit 2 set by software drives the active-low shutdown output low.
// - Special control one bit 3 lets register writes override the permanent settings.
// - Special control two bit 0 puts the device into software power-down.
// - Lockout bit 0 blocks override of all register values.
// - Lockout bit 0 still leaves special control one bits 2..0 and special control two bit 0 writable.
// - Lockout bit 1 disables the one-time-programmable function entirely.
// - Lockout bit 3 keeps software power-down from taking effect.
// - Lockout bit 4 keeps software from asserting the shutdown output.
// - Lockout bits can only be set by writes and stay set until power-on reset.
`include "otpsf_map.svh"

module otpsf_ctrl
#(
    parameter int unsigned BLOW_CYCLES = `OTPSF_FUSE_BLOW_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port from the serial core
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rd_hit,
    // Fuse array
    input wire logic fuse_lock_burned,
    output logic fuse_sense_low_current,
    output logic fuse_blow,
    output logic fuse_busy,
    // Device controls
    output logic shutdown_out_n,
    output logic power_down,
    output logic override_active,
    output logic reg_override_allow,
    output logic otp_allow
);

    // Registered state and its next value
    otpsf_pkg::otpsf_ctrl_t st;
    otpsf_pkg::otpsf_ctrl_t next_st;
    otpsf_fuse_if fuse_bus ();

    // Decoded write strobes and lock views
    logic wr_pl;
    logic wr_s1;
    logic wr_s2;
    logic wr_lk;
    logic ovr_locked;
    logic blow_ok;
    logic [7:0] lockout_next;
    logic shutdown_locked_next;
    logic pdown_locked_next;
    logic ovr_locked_next;
    logic otp_locked_next;

    // Readback mux over the current state
    logic [7:0] read_byte;
    logic read_mapped;

    otpsf_fuse_seq
    #(
        .BLOW_CYCLES(BLOW_CYCLES)
    )
    u_fuse_seq
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .fuse(fuse_bus.seq)
    );

    assign wr_pl = wr_en && (addr == `OTPSF_ADDR_PROG_LOCK);
    assign wr_s1 = wr_en && (addr == `OTPSF_ADDR_SPECIAL_ONE);
    assign wr_s2 = wr_en && (addr == `OTPSF_ADDR_SPECIAL_TWO);
    assign wr_lk = wr_en && (addr == `OTPSF_ADDR_LOCKOUT);
    assign ovr_locked = st.lockout[`OTPSF_LK_OVR_BIT];
    // Blowing needs the enable, an unlocked OTP function and an unburned program lock
    assign blow_ok = st.fuse_blow_enable && !fuse_lock_burned;

    // Lockout bits are set-only; zeros written are ignored
    assign lockout_next = wr_lk ? (st.lockout | (wdata & `OTPSF_LK_MASK)) : st.lockout;
    // A lock set by this very write already gates the outputs it launches
    assign shutdown_locked_next = lockout_next[`OTPSF_LK_SHUTDOWN_BIT];
    assign pdown_locked_next = lockout_next[`OTPSF_LK_PDOWN_BIT];
    assign ovr_locked_next = lockout_next[`OTPSF_LK_OVR_BIT];
    assign otp_locked_next = lockout_next[`OTPSF_LK_OTP_BIT];

    // Readback mux over the current state; reserved bits read 0
    always_comb
    begin
        read_byte = 8'h00;
        read_mapped = 1'b1;
        case (addr)
            `OTPSF_ADDR_PROG_LOCK:
            begin
                read_byte[`OTPSF_PL_LOCK_BIT] = fuse_lock_burned;
            end
            `OTPSF_ADDR_SPECIAL_ONE:
            begin
                read_byte[`OTPSF_S1_SENSE_BIT] = st.sense_low;
                read_byte[`OTPSF_S1_BLOW_BIT] = st.blow_en;
                read_byte[`OTPSF_S1_SHUTDOWN_BIT] = st.sw_shutdown;
                read_byte[`OTPSF_S1_OVR_BIT] = st.override;
            end
            `OTPSF_ADDR_SPECIAL_TWO:
            begin
                read_byte[`OTPSF_S2_PDOWN_BIT] = st.sw_pdown;
            end
            `OTPSF_ADDR_LOCKOUT:
            begin
                read_byte = st.lockout;
            end
            default:
            begin
                read_mapped = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.burn_start = 1'b0;

        // Special control one: low three bits stay writable under the override lock
        if (wr_s1)
        begin
            next_st.sense_low = wdata[`OTPSF_S1_SENSE_BIT];
            next_st.blow_en = wdata[`OTPSF_S1_BLOW_BIT];
            next_st.sw_shutdown = wdata[`OTPSF_S1_SHUTDOWN_BIT];
            if (!ovr_locked)
            begin
                next_st.override = wdata[`OTPSF_S1_OVR_BIT];
            end
        end

        // Special control two
        if (wr_s2)
        begin
            next_st.sw_pdown = wdata[`OTPSF_S2_PDOWN_BIT];
        end

        // Lockout follows the set-only merge
        next_st.lockout = lockout_next;

        // Writing the program lock only requests a burn; nothing volatile is kept
        if (wr_pl && wdata[`OTPSF_PL_LOCK_BIT] && blow_ok && !fuse_bus.busy)
        begin
            next_st.burn_start = 1'b1;
        end

        // Readback holds its byte until the next mapped or unmapped read
        next_st.rd_hit = 1'b0;
        if (rd_en)
        begin
            next_st.rdata = read_byte;
            next_st.rd_hit = read_mapped;
        end

        // Registered device controls, from the post-write state
        next_st.shutdown_out_n = !(next_st.sw_shutdown && !shutdown_locked_next);
        next_st.power_down = next_st.sw_pdown && !pdown_locked_next;
        next_st.override_active = next_st.override && !ovr_locked_next;
        next_st.reg_override_allow = !ovr_locked_next;
        next_st.otp_allow = !otp_locked_next && !fuse_lock_burned;
        next_st.fuse_blow_enable = next_st.blow_en && next_st.otp_allow;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st.sense_low <= 1'(`OTPSF_SPECIAL_ONE_RESET >> `OTPSF_S1_SENSE_BIT);
            st.blow_en <= 1'(`OTPSF_SPECIAL_ONE_RESET >> `OTPSF_S1_BLOW_BIT);
            st.sw_shutdown <= 1'(`OTPSF_SPECIAL_ONE_RESET >> `OTPSF_S1_SHUTDOWN_BIT);
            st.override <= 1'b0;
            st.sw_pdown <= 1'b0;
            st.lockout <= `OTPSF_LOCKOUT_RESET;
            st.burn_start <= 1'b0;
            st.rdata <= 8'h00;
            st.rd_hit <= 1'b0;
            st.shutdown_out_n <= 1'b1;
            st.power_down <= 1'b0;
            st.override_active <= 1'b0;
            st.fuse_blow_enable <= 1'b0;
            st.reg_override_allow <= 1'b1;
            st.otp_allow <= 1'b1;
        end
        // Clock enable low freezes every field, the burn request included
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // Start is gated by ce so a frozen bank never launches a blow
    assign fuse_bus.start = st.burn_start && ce;

    assign rdata = st.rdata;
    assign rd_hit = st.rd_hit;
    assign fuse_sense_low_current = st.sense_low;
    assign fuse_blow = fuse_bus.blow;
    assign fuse_busy = fuse_bus.busy;
    assign shutdown_out_n = st.shutdown_out_n;
    assign power_down = st.power_down;
    assign override_active = st.override_active;
    assign reg_override_allow = st.reg_override_allow;
    assign otp_allow = st.otp_allow;

endmodule // otpsf_ctrl

// ### dv/otpsf_ctrl_properties.sv
// Checker for the special-function control bank, bound to otpsf_ctrl.
// Assumes ce is held high.
module otpsf_ctrl_properties
#(
    parameter int unsigned BLOW_CYCLES = 4
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rd_hit,
    // Fuse and controls
    input wire logic fuse_lock_burned,
    input wire logic fuse_sense_low_current,
    input wire logic fuse_blow,
    input wire logic shutdown_out_n,
    input wire logic power_down,
    input wire logic override_active,
    input wire logic reg_override_allow,
    input wire logic otp_allow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [7:0] lk;
    logic s1b;
    logic [15:0] bc;
    logic br;
    assign br = wr_en && addr == 8'h15 && wdata[3] && s1b && !lk[1] && !fuse_lock_burned;
    // Shadow of the set-only lockout, blow enable and blow length
    always_ff @(posedge clk)
    begin
        lk <= rst ? 8'h00 : (wr_en && addr == 8'h18) ? lk | (wdata & 8'h1b) : lk;
        s1b <= rst ? 1'b0 : (wr_en && addr == 8'h16) ? wdata[1] : s1b;
        bc <= fuse_blow ? bc + 16'h0001 : 16'h0000;
    end
    shutdown_drive_a: assert property (wr_en && addr == 8'h16 && wdata[2] && !lk[4] |=> !shutdown_out_n)
        else $error("shutdown not driven");
    shutdown_block_a: assert property (lk[4] |-> shutdown_out_n)
        else $error("shutdown asserted while locked");
    pdown_set_a: assert property (wr_en && addr == 8'h17 && wdata[0] && !lk[3] |=> power_down)
        else $error("power-down not entered");
    pdown_block_a: assert property (lk[3] |-> !power_down)
        else $error("power-down while locked");
    ovr_block_a: assert property (lk[0] |-> !reg_override_allow)
        else $error("override allowed while locked");
    ovr_gate_a: assert property ($rose(override_active) |-> $past(wr_en && addr == 8'h16 && wdata[3] && !lk[0]))
        else $error("override rose without cause");
    otp_lock_a: assert property ((lk[1] || $past(fuse_lock_burned)) && !$past(rst) |-> !otp_allow)
        else $error("otp allowed while disabled");
    lock_read_a: assert property (rd_en && addr == 8'h18 |=> rd_hit && rdata == $past(lk))
        else $error("lockout readback wrong");
    sense_sel_a: assert property (wr_en && addr == 8'h16 |=> fuse_sense_low_current == $past(wdata[0]))
        else $error("sense current select wrong");
    blow_cause_a: assert property ($rose(fuse_blow) |-> $past(br, 2))
        else $error("fuse blown without permission");
    blow_len_a: assert property ($fell(fuse_blow) |-> bc == 16'(BLOW_CYCLES))
        else $error("blow pulse length wrong");
    cover property ($rose(fuse_blow));
    cover property (!shutdown_out_n);
    cover property (power_down);
endmodule // otpsf_ctrl_properties

bind otpsf_ctrl otpsf_ctrl_properties #(.BLOW_CYCLES(BLOW_CYCLES)) u_otpsf_ctrl_properties
(
    .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .rd_hit(rd_hit), .fuse_lock_burned(fuse_lock_burned), .fuse_sense_low_current(fuse_sense_low_current),
    .fuse_blow(fuse_blow), .shutdown_out_n(shutdown_out_n), .power_down(power_down),
    .override_active(override_active), .reg_override_allow(reg_override_allow), .otp_allow(otp_allow)
);

// ### dv/otpsf_fuse_model.sv
// Fuse array model: the program-lock fuse burns after one full-length blow pulse.
// Nonvolatile, so it ignores reset.
module otpsf_fuse_model
#(
    parameter int unsigned BLOW_CYCLES = 4
)
(
    input wire logic clk,
    input wire logic fuse_blow,
    output logic fuse_lock_burned
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned run = 0;
    logic burned = 1'b0;
    assign fuse_lock_burned = burned;
    always @(posedge clk)
    begin
        if (fuse_blow)
            run <= run + 1;
        else
        begin
            if (run >= BLOW_CYCLES)
                burned <= 1'b1;
            run <= 0;
        end
    end
endmodule // otpsf_fuse_model

// ### dv/test_otp_lock_and_special_function_ctrl.sv
// Self-checking bench for the special-function control bank.
// Assumes a byte strobe register port and the fuse array model.
module test_otp_lock_and_special_function_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rd_hit, fuse_lock_burned, fuse_sense_low_current, fuse_blow, fuse_busy;
    logic shutdown_out_n, power_down, override_active, reg_override_allow, otp_allow;
    logic [7:0] exp_q[$];
    logic [15:0] rnd = 16'h0a02;
    int err_count = 0;
    int comparisons = 0;
    int i;

    otpsf_ctrl #(.BLOW_CYCLES(BC)) u_otpsf_ctrl
    (
        .clk(clk), .rst(rst), .ce(1'b1), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .rd_hit(rd_hit), .fuse_lock_burned(fuse_lock_burned),
        .fuse_sense_low_current(fuse_sense_low_current), .fuse_blow(fuse_blow), .fuse_busy(fuse_busy),
        .shutdown_out_n(shutdown_out_n), .power_down(power_down), .override_active(override_active),
        .reg_override_allow(reg_override_allow), .otp_allow(otp_allow)
    );
    otpsf_fuse_model #(.BLOW_CYCLES(BC)) u_otpsf_fuse_model
    (
        .clk(clk), .fuse_blow(fuse_blow), .fuse_lock_burned(fuse_lock_burned)
    );

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: level %b expected %b", $time, got, exp);
        end
    endtask

    // One access per falling edge; strobes stay up until the next call
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        wr_en = w;
        rd_en = r;
        addr = a;
        wdata = v;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(negedge clk)
    begin
        if (rd_hit === 1'b1)
            cmp8(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end

    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(8'h15, 8'h00);
        rd(8'h16, 8'h00);
        rd(8'h17, 8'h00);
        rd(8'h18, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            op(1'b1, 1'b0, 8'h16, rnd[7:0]);
            rd(8'h16, rnd[7:0] & 8'h0f);
            chk1(fuse_sense_low_current, rnd[0]);
            chk1(shutdown_out_n, !rnd[2]);
            chk1(override_active, rnd[3]);
            chk1(reg_override_allow, 1'b1);
            op(1'b1, 1'b0, 8'h17, rnd[15:8]);
            rd(8'h17, rnd[15:8] & 8'h01);
            chk1(power_down, rnd[8]);
        end
        op(1'b0, 1'b1, 8'h19, 8'h00);
        idle(1);
        cmp8(rdata, 8'h00);
        chk1(rd_hit, 1'b0);
        op(1'b1, 1'b0, 8'h16, 8'h04);
        op(1'b1, 1'b0, 8'h17, 8'h01);
        idle(1);
        chk1(shutdown_out_n, 1'b0);
        chk1(power_down, 1'b1);
        op(1'b1, 1'b0, 8'h16, 8'h00);
        op(1'b1, 1'b0, 8'h15, 8'h08);
        idle(3);
        chk1(fuse_busy, 1'b0);
        rd(8'h15, 8'h00);
        op(1'b1, 1'b0, 8'h16, 8'h02);
        op(1'b1, 1'b0, 8'h15, 8'h08);
        idle(3);
        chk1(fuse_blow, 1'b1);
        for (i = 0; i < 20 && fuse_busy !== 1'b0; i++)
            idle(1);
        chk1(fuse_busy, 1'b0);
        if (fuse_busy !== 1'b0)
            complete_run();
        idle(1);
        chk1(otp_allow, 1'b0);
        rd(8'h15, 8'h08);
        op(1'b1, 1'b0, 8'h15, 8'h08);
        idle(3);
        chk1(fuse_blow, 1'b0);
        op(1'b1, 1'b0, 8'h18, 8'hff);
        op(1'b1, 1'b0, 8'h18, 8'h00);
        rd(8'h18, 8'h1b);
        op(1'b1, 1'b0, 8'h16, 8'h0f);
        op(1'b1, 1'b0, 8'h17, 8'h01);
        rd(8'h16, 8'h07);
        rd(8'h17, 8'h01);
        idle(1);
        chk1(shutdown_out_n, 1'b1);
        chk1(power_down, 1'b0);
        chk1(reg_override_allow, 1'b0);
        chk1(override_active, 1'b0);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(8'h18, 8'h00);
        rd(8'h15, 8'h08);
        chk1(reg_override_allow, 1'b1);
        idle(3);
        chk1(exp_q.size() == 0, 1'b1);
        complete_run();
    end
endmodule // test_otp_lock_and_special_function_ctrl
